/* File: rtl/sns_trim_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sns_trim_top (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_wr_en,
  input  wire logic             i_rd_en,
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wr_data,
  output logic      [7:0]       o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_pcfg_wr,
  input  wire logic             i_pcfg_data,
  output logic                  o_persistent_config_bit,
  output logic                  o_soft_reset,
  input  wire logic [1:0]       i_ch_enable,
  input  wire logic [1:0][7:0]  i_ramp_step_divider,
  output logic      [1:0]       o_channel_force_off,
  output logic      [1:0][2:0]  o_sense_trim_code,
  output logic      [1:0][14:0] o_sense_offset_uv,
  output logic      [1:0][7:0]  o_ramp_level,
  output logic      [1:0]       o_ramp_done,
  output logic      [1:0]       o_gate_allow
);
  import sns_pkg::*;

  logic [7:0] cal;
  logic [7:0] next_cal;
  logic       pcfg;
  logic       next_pcfg;
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  logic       rd_valid;
  logic       next_rd_valid;
  logic       srst;
  logic       next_srst;
  logic       key_hit;
  logic       cal_wr;

  sns_chan_if ch_if [NUM_CH] ();

  function automatic logic [2:0] trim_code(input logic [7:0] r, input int unsigned c);
    trim_code = r[c*CAL_CH_STRIDE+CAL_TRIM_POS +: 3];
  endfunction

  function automatic logic force_bit(input logic [7:0] r, input int unsigned c);
    force_bit = r[c*CAL_CH_STRIDE+CAL_OFF_POS];
  endfunction

  function automatic logic [14:0] offset_uv(input logic [2:0] code);
    offset_uv = 15'(code * TRIM_STEP_UV);
  endfunction

  // Register write, soft reset and read path
  always_comb
  begin
    key_hit       = i_wr_en && (i_addr == ADDR_SRST) && (i_wr_data == SRST_KEY);
    cal_wr        = i_wr_en && (i_addr == ADDR_CAL);
    next_cal      = cal;
    next_pcfg     = pcfg;
    next_srst     = key_hit;
    next_rd_valid = i_rd_en;
    next_rd_data  = rd_data;
    // Non-key writes to the reset address fall through untouched
    if (key_hit)
      next_cal = CAL_RESET;
    else if (cal_wr)
      next_cal = i_wr_data;
    // Persistent bit is only ever written, never soft reset
    if (i_pcfg_wr)
      next_pcfg = i_pcfg_data;
    if (i_rd_en)
    begin
      if (i_addr == ADDR_CAL)
        next_rd_data = cal;
      else if (i_addr == ADDR_SRST)
        next_rd_data = SRST_READ;
      else
        next_rd_data = RD_RESET;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cal      <= CAL_RESET;
      pcfg     <= PCFG_RESET;
      rd_data  <= RD_RESET;
      rd_valid <= 1'b0;
      srst     <= 1'b0;
    end
    else
    begin
      cal      <= next_cal;
      pcfg     <= next_pcfg;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
      srst     <= next_srst;
    end
  end

  assign o_rd_data               = rd_data;
  assign o_rd_valid              = rd_valid;
  assign o_persistent_config_bit = pcfg;
  // Rest of the map restores its defaults on this pulse
  assign o_soft_reset            = srst;

  // Per-channel trim, force-off and ramp engines
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign o_sense_trim_code[g]   = trim_code(cal, g);
      assign o_sense_offset_uv[g]   = offset_uv(trim_code(cal, g));
      assign o_channel_force_off[g] = force_bit(cal, g);
      // Forced-off overrides the enable for as long as it is set
      assign ch_if[g].run           = i_ch_enable[g] && !force_bit(cal, g);
      assign ch_if[g].divider       = i_ramp_step_divider[g];
      assign o_ramp_level[g]        = ch_if[g].ramp_level;
      assign o_ramp_done[g]         = ch_if[g].ramp_done;
      assign o_gate_allow[g]        = ch_if[g].gate_allow;

      sns_chan u_chan (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .ch       (ch_if[g])
      );
    end
  endgenerate

  property p_cal_write;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_wr_en && (i_addr == ADDR_CAL) |=> (cal == $past(i_wr_data)) && (o_sense_trim_code[0] == cal[3:1]);
  endproperty
  a_cal_write: assert property (p_cal_write) else $error("calibration write not stored");

  property p_offset;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_sense_trim_code[1] == 3'h7) |-> (o_sense_offset_uv[1] == 15'h445c);
  endproperty
  a_offset: assert property (p_offset) else $error("top trim code offset wrong");

  property p_force_off;
    @(posedge i_clk) disable iff (!i_arst_n)
    cal[4] ##1 cal[4] |-> !o_gate_allow[1] && !o_ramp_done[1];
  endproperty
  a_force_off: assert property (p_force_off) else $error("forced-off channel still active");

  property p_key_reset;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_wr_en && (i_addr == ADDR_SRST) && (i_wr_data == SRST_KEY) |=> (cal == CAL_RESET) && o_soft_reset;
  endproperty
  a_key_reset: assert property (p_key_reset) else $error("key write did not reset");

  property p_nonkey;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_wr_en && (i_addr == ADDR_SRST) && (i_wr_data != SRST_KEY) |=> $stable(cal) && !o_soft_reset;
  endproperty
  a_nonkey: assert property (p_nonkey) else $error("non-key write changed state");

  property p_read_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_rd_en && (i_addr == ADDR_SRST) |=> o_rd_valid && (o_rd_data == 8'h00);
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("reset register read not zero");

  property p_pcfg_keep;
    @(posedge i_clk) disable iff (!i_arst_n)
    o_soft_reset && !$past(i_pcfg_wr) |-> (o_persistent_config_bit == $past(o_persistent_config_bit));
  endproperty
  a_pcfg_keep: assert property (p_pcfg_keep) else $error("soft reset touched persistent bit");

  // Field, bus, pulse and hold checks, and the persistent bit write path
  property p_force_off0;
    @(posedge i_clk) disable iff (!i_arst_n)
    cal[0] ##1 cal[0] |-> !o_gate_allow[0] && !o_ramp_done[0];
  endproperty
  a_force_off0: assert property (p_force_off0) else $error("forced-off first channel still active");

  property p_offset_step;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_sense_trim_code[0] == 3'h1) |-> (o_sense_offset_uv[0] == 15'h09c4);
  endproperty
  a_offset_step: assert property (p_offset_step) else $error("single trim step offset wrong");

  property p_offset_zero;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_sense_trim_code[1] == 3'h0) |-> (o_sense_offset_uv[1] == 15'h0000);
  endproperty
  a_offset_zero: assert property (p_offset_zero) else $error("zero trim code offset not zero");

  property p_rd_cal;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_rd_en && (i_addr == ADDR_CAL) |=> o_rd_valid && (o_rd_data == $past(cal));
  endproperty
  a_rd_cal: assert property (p_rd_cal) else $error("calibration readback wrong");

  property p_rd_pulse;
    @(posedge i_clk) disable iff (!i_arst_n)
    !i_rd_en |=> !o_rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid without a read");

  property p_rd_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    !i_rd_en |=> $stable(o_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved between reads");

  property p_srst_pulse;
    @(posedge i_clk) disable iff (!i_arst_n)
    !(i_wr_en && (i_addr == ADDR_SRST) && (i_wr_data == SRST_KEY)) |=> !o_soft_reset;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset without key write");

  property p_cal_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    !(i_wr_en && (i_addr == ADDR_CAL)) && !(i_wr_en && (i_addr == ADDR_SRST) && (i_wr_data == SRST_KEY))
      |=> $stable(cal);
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration changed without a write");

  property p_pcfg_write;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_pcfg_wr |=> (o_persistent_config_bit == $past(i_pcfg_data));
  endproperty
  a_pcfg_write: assert property (p_pcfg_write) else $error("persistent bit write not stored");
endmodule
`default_nettype wire

/* File: common/sns_pkg.sv */
// Function
// - Three-bit trim adds 2.5 mV per step
// - Forced-off bit holds its channel shut down
// - Key byte write restores writable register defaults
// - Reset register write-only, reads return zero
// - Persistent bit survives soft reset, powers up one
// - Soft-start counts 256 steps of divider periods
// - Oscillator caps duty at 90 percent
`default_nettype none
package sns_pkg;
  // Register map
  localparam logic [7:0] ADDR_CAL       = 8'h25;
  localparam logic [7:0] ADDR_SRST      = 8'h26;
  localparam logic [7:0] SRST_KEY       = 8'hc3;
  localparam logic [7:0] CAL_RESET      = 8'h00;
  localparam logic [7:0] SRST_READ      = 8'h00;
  localparam logic [7:0] RD_RESET       = 8'h00;
  localparam logic       PCFG_RESET     = 1'b1;

  // Calibration field layout, channel index times stride
  localparam int unsigned CAL_CH_STRIDE = 4;
  localparam int unsigned CAL_OFF_POS   = 0;
  localparam int unsigned CAL_TRIM_POS  = 1;
  localparam int unsigned NUM_CH        = 2;

  // Trim step in microvolts
  localparam int unsigned TRIM_STEP_UV  = 2500;

  // Soft-start ramp
  localparam int unsigned RAMP_COUNTS   = 256;
  localparam logic [7:0]  RAMP_LAST     = 8'(RAMP_COUNTS - 1);

  // Oscillator timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SW_PERIOD_PS  = 2500000;
  localparam int unsigned DUTY_MAX_PCT  = 90;
  localparam int unsigned SW_PERIOD_CYC = SW_PERIOD_PS / CLK_PERIOD_PS;
  localparam int unsigned MAX_ON_CYC    = (SW_PERIOD_CYC * DUTY_MAX_PCT) / 100;
  localparam int unsigned PHASE_W       = 9;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SW_PERIOD_CYC - 1);
  localparam logic [PHASE_W-1:0] MAX_ON     = PHASE_W'(MAX_ON_CYC);
endpackage
`default_nettype wire

/* File: common/sns_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sns_chan_if;
  logic       run;
  logic [7:0] divider;
  logic [7:0] ramp_level;
  logic       ramp_done;
  logic       gate_allow;

  modport ctl  (output run, divider, input ramp_level, ramp_done, gate_allow);
  modport chan (input run, divider, output ramp_level, ramp_done, gate_allow);
endinterface
`default_nettype wire

/* File: rtl/sns_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module sns_chan (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  sns_chan_if.chan  ch
);
  import sns_pkg::*;

  typedef enum logic [1:0]
  {
    SNS_OFF  = 2'b00,
    SNS_RAMP = 2'b01,
    SNS_ON   = 2'b11
  } sns_state_t;

  sns_state_t         state;
  sns_state_t         next_state;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W-1:0] next_phase;
  logic [7:0]         step_cnt;
  logic [7:0]         next_step_cnt;
  logic [7:0]         level;
  logic [7:0]         next_level;
  logic               period_end;
  logic [7:0]         step_last;

  // Free-running oscillator phase and ramp sequencing
  always_comb
  begin
    period_end    = (phase == PHASE_LAST);
    next_phase    = period_end ? '0 : phase + 1'b1;
    // Divider of zero behaves as one period, avoids a stuck ramp
    step_last     = (ch.divider == 8'h00) ? 8'h00 : ch.divider - 8'h01;
    next_state    = state;
    next_step_cnt = step_cnt;
    next_level    = level;
    case (state)
      SNS_OFF:
      begin
        next_step_cnt = 8'h00;
        next_level    = 8'h00;
        if (ch.run)
          next_state = SNS_RAMP;
      end
      SNS_RAMP:
      begin
        if (!ch.run)
        begin
          // Level drops with the state, no stale count left on the way out
          next_state    = SNS_OFF;
          next_step_cnt = 8'h00;
          next_level    = 8'h00;
        end
        else if (period_end)
        begin
          if (step_cnt >= step_last)
          begin
            next_step_cnt = 8'h00;
            if (level == RAMP_LAST)
              next_state = SNS_ON;
            else
              next_level = level + 8'h01;
          end
          else
            next_step_cnt = step_cnt + 8'h01;
        end
      end
      SNS_ON:
      begin
        if (!ch.run)
        begin
          next_state    = SNS_OFF;
          next_step_cnt = 8'h00;
          next_level    = 8'h00;
        end
      end
      default:
        next_state = SNS_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state    <= SNS_OFF;
      phase    <= '0;
      step_cnt <= 8'h00;
      level    <= 8'h00;
    end
    else
    begin
      state    <= next_state;
      phase    <= next_phase;
      step_cnt <= next_step_cnt;
      level    <= next_level;
    end
  end

  // Off-time guaranteed at the tail of every period
  assign ch.gate_allow = (state != SNS_OFF) && (phase < MAX_ON);
  assign ch.ramp_level = level;
  assign ch.ramp_done  = (state == SNS_ON);

  property p_ramp_step;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state == SNS_RAMP) && ch.run && period_end && (step_cnt >= step_last) && (level != RAMP_LAST)
      |=> (level == $past(level) + 8'h01);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp level did not advance");

  property p_ramp_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state == SNS_RAMP) && ch.run && !period_end |=> $stable(level);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp level moved mid period");

  property p_min_off;
    @(posedge i_clk) disable iff (!i_arst_n)
    (phase >= MAX_ON) |-> !ch.gate_allow;
  endproperty
  a_min_off: assert property (p_min_off) else $error("gate allowed in off window");

  property p_off_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    !ch.run ##1 !ch.run |-> !ch.gate_allow && (level == 8'h00) && !ch.ramp_done;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("channel active while not running");
endmodule
`default_nettype wire

/* File: verification/sns_trim_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sns_trim_top_bench;
  import sns_pkg::*;
  logic             i_clk;
  logic             i_arst_n;
  logic             i_wr_en;
  logic             i_rd_en;
  logic [7:0]       i_addr;
  logic [7:0]       i_wr_data;
  logic [7:0]       o_rd_data;
  logic             o_rd_valid;
  logic             i_pcfg_wr;
  logic             i_pcfg_data;
  logic             o_persistent_config_bit;
  logic             o_soft_reset;
  logic [1:0]       i_ch_enable;
  logic [1:0][7:0]  i_ramp_step_divider;
  logic [1:0]       o_channel_force_off;
  logic [1:0][2:0]  o_sense_trim_code;
  logic [1:0][14:0] o_sense_offset_uv;
  logic [1:0][7:0]  o_ramp_level;
  logic [1:0]       o_ramp_done;
  logic [1:0]       o_gate_allow;
  int               err_total;
  int               comparisons;
  int               highs;
  logic [7:0]       cal;
  logic [7:0]       dat;
  logic [1:0][7:0]  lvl;

  sns_trim_top i_sns_trim_top (
    .i_clk                   (i_clk),
    .i_arst_n                (i_arst_n),
    .i_wr_en                 (i_wr_en),
    .i_rd_en                 (i_rd_en),
    .i_addr                  (i_addr),
    .i_wr_data               (i_wr_data),
    .o_rd_data               (o_rd_data),
    .o_rd_valid              (o_rd_valid),
    .i_pcfg_wr               (i_pcfg_wr),
    .i_pcfg_data             (i_pcfg_data),
    .o_persistent_config_bit (o_persistent_config_bit),
    .o_soft_reset            (o_soft_reset),
    .i_ch_enable             (i_ch_enable),
    .i_ramp_step_divider     (i_ramp_step_divider),
    .o_channel_force_off     (o_channel_force_off),
    .o_sense_trim_code       (o_sense_trim_code),
    .o_sense_offset_uv       (o_sense_offset_uv),
    .o_ramp_level            (o_ramp_level),
    .o_ramp_done             (o_ramp_done),
    .o_gate_allow            (o_gate_allow)
  );

  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    end_of_test();
  end

  task automatic end_of_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected field values worked out from the register layout
  function automatic logic [2:0] trim_of(input logic [7:0] c, input int ch);
    return c[ch*CAL_CH_STRIDE+CAL_TRIM_POS +: 3];
  endfunction

  function automatic logic off_of(input logic [7:0] c, input int ch);
    return c[ch*CAL_CH_STRIDE+CAL_OFF_POS];
  endfunction

  // Strobes rise after one edge and fall after the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk("rd_valid", 32'(o_rd_valid), 32'h1);
    d = o_rd_data;
  endtask

  // Field outputs, shutdown of forced channels, then readback
  task automatic check_cal(input logic [7:0] c);
    logic [7:0] r;
    @(posedge i_clk);
    #1;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      chk("trim", 32'(o_sense_trim_code[ch]), 32'(trim_of(c, ch)));
      chk("offset_uv", 32'(o_sense_offset_uv[ch]), 32'(trim_of(c, ch)) * TRIM_STEP_UV);
      chk("force_off", 32'(o_channel_force_off[ch]), 32'(off_of(c, ch)));
      if (off_of(c, ch))
      begin
        chk("gate_forced", 32'(o_gate_allow[ch]), 32'h0);
        chk("level_forced", 32'(o_ramp_level[ch]), 32'h0);
      end
    end
    rd(ADDR_CAL, r);
    chk("cal_read", 32'(r), 32'(c));
  endtask

  initial
  begin
    i_arst_n            = 1'b0;
    i_wr_en             = 1'b0;
    i_rd_en             = 1'b0;
    i_addr              = 8'h00;
    i_wr_data           = 8'h00;
    i_pcfg_wr           = 1'b0;
    i_pcfg_data         = 1'b0;
    i_ch_enable         = 2'b11;
    i_ramp_step_divider = {8'h03, 8'h00};
    err_total           = 0;
    comparisons         = 0;
    void'($urandom(32'hed73));
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("pcfg_por", 32'(o_persistent_config_bit), 32'(PCFG_RESET));
    check_cal(CAL_RESET);
    @(posedge i_clk);
    i_pcfg_wr <= 1'b1;
    @(posedge i_clk);
    i_pcfg_wr <= 1'b0;
    // Corners first: all trims at top code, then both channels forced
    for (int i = 0; i < 8; i++)
    begin
      cal = (i == 0) ? 8'hee : (i == 1) ? 8'h11 : 8'($urandom);
      wr(ADDR_CAL, cal);
      check_cal(cal);
    end
    // The value next to the key, then random non-key values, must change nothing
    for (int i = 0; i < 4; i++)
    begin
      dat = (i == 0) ? 8'hc2 : 8'($urandom);
      if (dat == SRST_KEY)
        dat = 8'h3c;
      wr(ADDR_SRST, dat);
      #1;
      chk("no_pulse", 32'(o_soft_reset), 32'h0);
      check_cal(cal);
    end
    rd(ADDR_SRST, dat);
    chk("key_read", 32'(dat), 32'(SRST_READ));
    wr(ADDR_SRST, SRST_KEY);
    #1;
    chk("soft_reset", 32'(o_soft_reset), 32'h1);
    chk("pcfg_kept", 32'(o_persistent_config_bit), 32'h0);
    // Pulse must be gone one cycle later, not just eventually
    @(posedge i_clk);
    #1;
    chk("pulse_end", 32'(o_soft_reset), 32'h0);
    check_cal(CAL_RESET);
    // Only the power-on reset brings the persistent bit back
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("pcfg_reset", 32'(o_persistent_config_bit), 32'h1);
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Settle past the first partial step, then measure whole step windows
    repeat (1500) @(posedge i_clk);
    #1;
    lvl = o_ramp_level;
    repeat (1500) @(posedge i_clk);
    #1;
    chk("ramp_div0", 32'(o_ramp_level[0]), 32'(lvl[0]) + 3);
    chk("ramp_div3", 32'(o_ramp_level[1]), 32'(lvl[1]) + 1);
    chk("ramp_done", 32'(o_ramp_done), 32'h0);
    highs = 0;
    repeat (SW_PERIOD_CYC)
    begin
      @(posedge i_clk);
      #1;
      highs += int'(o_gate_allow[0]);
    end
    chk("duty", 32'(highs), 32'(MAX_ON_CYC));
    end_of_test();
  end
endmodule
`default_nettype wire
